// [rtl/pss_pkg.sv]
// Package for the peripheral select strap block: state, select carriers.
// Assumes a single 10 MHz system clock and active-low async reset.
package pss_pkg;

    // Strap capture sequence
    typedef enum logic [1:0] {PSS_IN_RESET, PSS_CAPTURE, PSS_RUN} pss_state_t;

    // Latched straps, one bit each
    typedef struct packed {
        logic cell_port_select;
        logic pci_select;
        logic serial_two_select;
        logic eeprom_autoinit_strap;
    } pss_straps_t;

    // Peripheral enables that steer the pin muxes
    typedef struct packed {
        logic cell_port_en;
        logic serial_one_en;
        logic host_port_en;
        logic gp_high_avail;
        logic pci_en;
        logic serial_two_en;
        logic eeprom_en;
        logic autoinit_req;
    } pss_enables_t;

    // Output-enable values (active low: low means the block drives)
    localparam logic PSS_OE_DRIVE = 1'b0;
    localparam logic PSS_OE_HIZ = 1'b1;
    localparam logic PSS_STRAP_DEFAULT = 1'b0;
    localparam int PSS_GP_HIGH_W = 7;
    localparam int PSS_GP_LOW_W = 9;

endpackage : pss_pkg

// [rtl/pss_decode.sv]
// Combinational decode from latched straps to peripheral enables.
// Assumes straps are stable; the serial-two select is the live pin value.
`timescale 1ns/1ns
module pss_decode
    import pss_pkg::*;
(
    input wire pss_pkg::pss_straps_t straps,
    output pss_pkg::pss_enables_t enables
);
    import pss_pkg::*;

    // Each pair of sharing peripherals takes complementary terms
    always_comb
    begin
        enables.cell_port_en = straps.cell_port_select;
        enables.serial_one_en = ~straps.cell_port_select;
        enables.host_port_en = ~straps.pci_select;
        enables.gp_high_avail = ~straps.pci_select;
        enables.pci_en = straps.pci_select;
        enables.serial_two_en = ~straps.pci_select
            | straps.serial_two_select;
        enables.eeprom_en = straps.pci_select
            & ~straps.serial_two_select;
        enables.autoinit_req = straps.pci_select
            & ~straps.serial_two_select
            & straps.eeprom_autoinit_strap;
    end

endmodule : pss_decode

// [rtl/pss_straps.sv]
// Peripheral select strap block: captures straps at reset, steers muxes.
// Assumes strap pins are valid and synchronous to SYS_CLK during reset.
`timescale 1ns/1ns
// Notes on behaviour
// - Capture strap levels during reset, configure from them
// - Never enable two peripherals on one pin
// - Coprocessors, timers, serial zero, low GP always on
// - Cell select 0: serial one, cell-only pins Hi-Z
// - Cell select 1: cell port, serial-one-only pins Hi-Z
// - PCI select 0: host port, GP high available
// - PCI select 0: byte enable, chip select Hi-Z
// - PCI select 1: host off, shared pins PCI
// - Serial two off only when PCI 1, select 0
// - Auto-init when strap 1, PCI, serial two off
// - Live serial-two select enables it, disables EEPROM
// - Auto-init strap 0 leaves PCI defaults
module pss_straps
    import pss_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CELL_SELECT_STRAP_PIN,
    input wire logic PCI_SELECT_PIN,
    input wire logic SERIAL_TWO_SELECT_PIN,
    input wire logic AUTOINIT_STRAP_PIN,
    input wire logic [pss_pkg::PSS_GP_HIGH_W-1:0] GP_HIGH_ENABLE,
    input wire logic [pss_pkg::PSS_GP_HIGH_W-1:0] GP_HIGH_DIR_OUT,
    output logic STRAPS_VALID,
    output pss_pkg::pss_enables_t ENABLES,
    output logic AUTOINIT_START,
    output logic CELL_ONLY_OE_N,
    output logic SERIAL_ONE_ONLY_OE_N,
    output logic PCI_ONLY_OE_N,
    output logic [pss_pkg::PSS_GP_HIGH_W-1:0] GP_HIGH_GPIO_OE_N,
    output logic ALWAYS_ON_EN
);
    import pss_pkg::*;

    pss_state_t state_reg, state_next;
    pss_straps_t latch_reg, latch_next;
    pss_straps_t live;
    pss_enables_t dec, en_reg, en_next;
    logic start_reg, start_next;
    logic [PSS_GP_HIGH_W-1:0] gp_oe_reg, gp_oe_next;
    logic in_reset_q;

    // Strap latch: loaded on every clock while reset is held, so the value
    // kept is the last level seen in reset. It has no async reset on
    // purpose: an async clear could only load a constant, never the pins,
    // and the strap pins may be reused as outputs once reset is released.
    always_comb
    begin
        latch_next = latch_reg;
        if (!RST_N)
        begin
            latch_next.cell_port_select = CELL_SELECT_STRAP_PIN;
            latch_next.pci_select = PCI_SELECT_PIN;
            latch_next.serial_two_select = SERIAL_TWO_SELECT_PIN;
            latch_next.eeprom_autoinit_strap = AUTOINIT_STRAP_PIN;
        end
    end

    // Reset release may land close to an edge; the pins still hold then,
    // so an early or late last load stores the same levels either way.
    always_ff @(posedge SYS_CLK)
    begin
        latch_reg <= latch_next;
    end

    // Capture sequence: two settling cycles after release before the
    // enables are declared valid and the auto-init pulse is issued.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PSS_IN_RESET:
                state_next = PSS_CAPTURE;
            PSS_CAPTURE:
                state_next = PSS_RUN;
            PSS_RUN:
                state_next = PSS_RUN; // Held until next reset
            default:
                state_next = PSS_IN_RESET;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= PSS_IN_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Serial-two select follows the live pin; the rest stay latched
    always_comb
    begin
        live = latch_reg;
        live.serial_two_select = SERIAL_TWO_SELECT_PIN;
    end

    pss_decode u_decode (
        .straps(live),
        .enables(dec)
    );

    // Enables are held off until straps are captured, so no pin drives
    // a wrong peripheral in the cycle of reset release.
    always_comb
    begin
        in_reset_q = (state_reg == PSS_IN_RESET);
        en_next = in_reset_q ? '0 : dec;
        // Auto-init looks at the reset-time serial-two level: a board that
        // flips the live select right after release must not cancel it.
        start_next = (state_reg == PSS_CAPTURE)
            & latch_reg.pci_select
            & ~latch_reg.serial_two_select
            & latch_reg.eeprom_autoinit_strap;
    end

    // Per-pin GPIO drive: only on available pins that software set up as
    // outputs; every other high GP pin stays Hi-Z.
    genvar gi;
    generate
        for (gi = 0; gi < PSS_GP_HIGH_W; gi = gi + 1)
        begin : g_gp_oe
            assign gp_oe_next[gi] = (dec.gp_high_avail & ~in_reset_q
                & GP_HIGH_ENABLE[gi] & GP_HIGH_DIR_OUT[gi])
                ? PSS_OE_DRIVE : PSS_OE_HIZ;
        end
    endgenerate

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            en_reg <= '0;
            start_reg <= 1'b0;
            gp_oe_reg <= '1;
        end
        else
        begin
            en_reg <= en_next;
            start_reg <= start_next;
            gp_oe_reg <= gp_oe_next;
        end
    end

    // Standalone pin tie-offs follow the registered enables
    assign ENABLES = en_reg;
    assign STRAPS_VALID = (state_reg == PSS_RUN);
    assign AUTOINIT_START = start_reg;
    assign CELL_ONLY_OE_N = en_reg.cell_port_en ? PSS_OE_DRIVE : PSS_OE_HIZ;
    assign SERIAL_ONE_ONLY_OE_N = en_reg.serial_one_en ? PSS_OE_DRIVE
        : PSS_OE_HIZ;
    assign PCI_ONLY_OE_N = en_reg.pci_en ? PSS_OE_DRIVE : PSS_OE_HIZ;
    assign GP_HIGH_GPIO_OE_N = gp_oe_reg;
    assign ALWAYS_ON_EN = 1'b1;

    // Pairs sharing pins never both on
    property p_exclusive;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !(ENABLES.cell_port_en && ENABLES.serial_one_en)
        && !(ENABLES.host_port_en && ENABLES.pci_en)
        && !(ENABLES.serial_two_en && ENABLES.eeprom_en);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("two peripherals share a pin");

    property p_hold;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID |=> $stable(ENABLES.cell_port_en)
            && $stable(ENABLES.pci_en);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched select changed after reset");

    // Valid rises two edges after the last edge in reset and is sampled high at the third
    property p_capture;
        @(posedge SYS_CLK) disable iff (!RST_N)
        $rose(STRAPS_VALID) |->
            ENABLES.cell_port_en == $past(CELL_SELECT_STRAP_PIN, 3)
            && ENABLES.pci_en == $past(PCI_SELECT_PIN, 3);
    endproperty
    a_capture: assert property (p_capture)
        else $error("cell select not captured from strap");

    property p_cell_hiz;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && !ENABLES.cell_port_en |-> CELL_ONLY_OE_N
            && !SERIAL_ONE_ONLY_OE_N;
    endproperty
    a_cell_hiz: assert property (p_cell_hiz)
        else $error("cell-only pins driven with serial one");

    property p_serial_hiz;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && ENABLES.cell_port_en |-> SERIAL_ONE_ONLY_OE_N;
    endproperty
    a_serial_hiz: assert property (p_serial_hiz)
        else $error("serial-one-only pins driven with cell port");

    property p_pci_hiz;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && ENABLES.host_port_en |-> PCI_ONLY_OE_N
            && ENABLES.gp_high_avail;
    endproperty
    a_pci_hiz: assert property (p_pci_hiz)
        else $error("pci-only pins driven with host port");

    property p_serial_two;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && SERIAL_TWO_SELECT_PIN |=>
            ENABLES.serial_two_en && !ENABLES.eeprom_en;
    endproperty
    a_serial_two: assert property (p_serial_two)
        else $error("live serial-two select not followed");

    property p_s2_off;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && ENABLES.pci_en && !SERIAL_TWO_SELECT_PIN |=>
            !ENABLES.serial_two_en;
    endproperty
    a_s2_off: assert property (p_s2_off)
        else $error("serial two not disabled");

    property p_autoinit;
        @(posedge SYS_CLK) disable iff (!RST_N)
        AUTOINIT_START |-> $past(PCI_SELECT_PIN, 3)
            && !$past(SERIAL_TWO_SELECT_PIN, 3)
            && $past(AUTOINIT_STRAP_PIN, 3)
            && $past(state_reg == PSS_CAPTURE);
    endproperty
    a_autoinit: assert property (p_autoinit)
        else $error("auto-init started without its conditions");

    property p_no_autoinit;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !latch_reg.eeprom_autoinit_strap |-> !AUTOINIT_START;
    endproperty
    a_no_autoinit: assert property (p_no_autoinit)
        else $error("auto-init with strap low");

    property p_gp;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ENABLES.pci_en |-> GP_HIGH_GPIO_OE_N == '1;
    endproperty
    a_gp: assert property (p_gp)
        else $error("gp high driven while pci owns pins");

    // Nothing but the always-on set is enabled or driven until the capture sequence is done
    property p_quiet;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !STRAPS_VALID |-> ENABLES == '0 && !AUTOINIT_START
            && CELL_ONLY_OE_N && SERIAL_ONE_ONLY_OE_N && PCI_ONLY_OE_N;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("enables active before straps captured");

    // PCI owns the shared host and GP pins once selected
    property p_host_off;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ENABLES.pci_en |-> !ENABLES.host_port_en && !ENABLES.gp_high_avail
            && !PCI_ONLY_OE_N;
    endproperty
    a_host_off: assert property (p_host_off)
        else $error("host port or gp left on with pci");

    // GP high pins follow the software bits one clock later
    property p_gp_drive;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && !ENABLES.pci_en |=> GP_HIGH_GPIO_OE_N
            == ~($past(GP_HIGH_ENABLE) & $past(GP_HIGH_DIR_OUT));
    endproperty
    a_gp_drive: assert property (p_gp_drive)
        else $error("gp high drive does not follow software bits");

    // Without PCI, serial two is always on and the EEPROM always off
    property p_s2_on;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID && !ENABLES.pci_en |->
            ENABLES.serial_two_en && !ENABLES.eeprom_en;
    endproperty
    a_s2_on: assert property (p_s2_on)
        else $error("serial two off without pci");

    // Auto-init is a single pulse per reset
    property p_start_pulse;
        @(posedge SYS_CLK) disable iff (!RST_N)
        AUTOINIT_START |=> !AUTOINIT_START;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("auto-init pulse longer than one cycle");

    // Valid stays up until the next reset
    property p_valid_hold;
        @(posedge SYS_CLK) disable iff (!RST_N)
        STRAPS_VALID |=> STRAPS_VALID;
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("straps valid dropped without reset");

    // Every reset with the auto-init conditions met issues the pulse
    property p_autoinit_due;
        @(posedge SYS_CLK) disable iff (!RST_N)
        $rose(STRAPS_VALID) && $past(PCI_SELECT_PIN, 3)
            && !$past(SERIAL_TWO_SELECT_PIN, 3)
            && $past(AUTOINIT_STRAP_PIN, 3) |-> AUTOINIT_START;
    endproperty
    a_autoinit_due: assert property (p_autoinit_due)
        else $error("auto-init not started");

endmodule : pss_straps

// [tb/pss_straps_tb.sv]
// Self-checking bench for the peripheral select strap block.
// Assumes the pss_pkg package and the pss_straps top module are compiled.
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            $display("wrong value at %0t ns: got %h, expected %h", \
                     $time, a, b); \
            error_cnt++; \
        end \
    end
module tb;
    import pss_pkg::*;

    logic sys_clk;
    logic rst_n;
    logic cell_strap;
    logic pci_sel;
    logic s2_sel;
    logic auto_strap;
    logic [PSS_GP_HIGH_W-1:0] gp_en;
    logic [PSS_GP_HIGH_W-1:0] gp_dir;
    logic straps_valid;
    pss_enables_t enables;
    logic autoinit_start;
    logic cell_oe_n;
    logic s1_oe_n;
    logic pci_oe_n;
    logic [PSS_GP_HIGH_W-1:0] gp_oe_n;
    logic always_on;
    int error_cnt;
    int checked;
    int cycles;

    pss_straps i_dut (
        .SYS_CLK(sys_clk),
        .RST_N(rst_n),
        .CELL_SELECT_STRAP_PIN(cell_strap),
        .PCI_SELECT_PIN(pci_sel),
        .SERIAL_TWO_SELECT_PIN(s2_sel),
        .AUTOINIT_STRAP_PIN(auto_strap),
        .GP_HIGH_ENABLE(gp_en),
        .GP_HIGH_DIR_OUT(gp_dir),
        .STRAPS_VALID(straps_valid),
        .ENABLES(enables),
        .AUTOINIT_START(autoinit_start),
        .CELL_ONLY_OE_N(cell_oe_n),
        .SERIAL_ONE_ONLY_OE_N(s1_oe_n),
        .PCI_ONLY_OE_N(pci_oe_n),
        .GP_HIGH_GPIO_OE_N(gp_oe_n),
        .ALWAYS_ON_EN(always_on)
    );

    // 10 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Expected peripheral enables; serial two follows the held live pin
    function automatic pss_enables_t exp_en(input logic c, input logic p,
                                            input logic s, input logic a);
        exp_en = '{c, ~c, ~p, ~p, p, ~p | s, p & ~s, p & ~s & a};
    endfunction : exp_en

    // Verdict and end of run
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // One reset with a strap set, then the capture walk c1..c3
    task automatic run_cfg(input logic c, input logic p, input logic s,
                           input logic a);
        pss_enables_t e;
        logic [PSS_GP_HIGH_W-1:0] g;
        e = exp_en(c, p, s, a);
        g = ~({PSS_GP_HIGH_W{~p}} & gp_en & gp_dir);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cell_strap <= c;
        pci_sel <= p;
        s2_sel <= s;
        auto_strap <= a;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(enables, pss_enables_t'(8'h00))
        `CHK({cell_oe_n, s1_oe_n, pci_oe_n, straps_valid}, 4'hE)
        `CHK(gp_oe_n, 7'h7F)
        @(posedge sys_clk);
        // Cell and auto-init straps flip at release; only the levels held in reset count
        rst_n <= 1'b1;
        cell_strap <= ~c;
        auto_strap <= ~a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(enables, pss_enables_t'(8'h00))
        `CHK(straps_valid, 1'b0)
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(enables, e)
        `CHK(cell_oe_n, ~c)
        `CHK(s1_oe_n, c)
        `CHK(pci_oe_n, ~p)
        `CHK(always_on, 1'b1)
        `CHK(straps_valid, 1'b1)
        `CHK(autoinit_start, p & ~s & a)
        `CHK(gp_oe_n, g)
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(autoinit_start, 1'b0)
        `CHK({enables, cell_oe_n}, {e, ~c})
    endtask : run_cfg

    // Hang guard, well above the roughly 190 cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        cell_strap = 1'b0;
        pci_sel = 1'b0;
        s2_sel = 1'b0;
        auto_strap = 1'b0;
        gp_en = 7'h55;
        gp_dir = 7'h33;
        error_cnt = 0;
        checked = 0;
        cycles = 0;
        repeat (5) @(posedge sys_clk);
        // Every strap combination
        for (int i = 0; i < 16; i++)
            run_cfg(i[3], i[2], i[1], i[0]);
        // Live serial-two select toggled after reset, PCI strap held
        run_cfg(1'b0, 1'b1, 1'b0, 1'b1);
        @(posedge sys_clk);
        s2_sel <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK({enables.serial_two_en, enables.eeprom_en}, 2'b10)
        `CHK({enables.pci_en, enables.host_port_en}, 2'b10)
        @(posedge sys_clk);
        s2_sel <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK({enables.serial_two_en, enables.eeprom_en}, 2'b01)
        // Software GPIO bits on the high pins with the host port selected
        run_cfg(1'b1, 1'b0, 1'b1, 1'b0);
        @(posedge sys_clk);
        gp_en <= 7'h7F;
        gp_dir <= 7'h7F;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(gp_oe_n, 7'h00)
        @(posedge sys_clk);
        gp_dir <= 7'h0F;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(gp_oe_n, 7'h70)
        stop_test();
    end

endmodule : tb
